/* cbz_card_model.sv */
`timescale 1ns/1ps
// ==========================================================
// card video sources, new word every cycle
module cbz_card_model #(
  parameter int VID_W = 16
)(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  output logic      [VID_W-1:0] vid0_out,
  output logic      [VID_W-1:0] vid1_out
);
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      vid0_out <= '0;
    else
      vid0_out <= vid0_out + 1'b1;
  end
  assign vid1_out = ~vid0_out;
endmodule : cbz_card_model

/* cbz_pkg.sv */
package cbz_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] SYSCTL_ADDR = 8'h80;
  localparam logic [7:0] MMCTL_ADDR  = 8'h84;
  localparam logic [7:0] STATUS_ADDR = 8'h88;
  // ==========================================================
  // system control bit positions
  localparam int UP_BURST_BIT   = 14;
  localparam int SOCK_SEEN_BIT  = 13;
  localparam int RAIL_BIT       = 12;
  localparam int STREAM_BIT     = 11;
  localparam int UP_SETTLE_BIT  = 10;
  localparam int DN_SETTLE_BIT  = 9;
  localparam int PROBE_BIT      = 8;
  localparam int ZERO_BIT       = 7;
  localparam int GATING_BIT     = 6;
  localparam int ID_LOCK_BIT    = 5;
  localparam int PAR_REPORT_BIT = 4;
  localparam int DMA_EN_BIT     = 3;
  localparam int CLK_INHIBIT_BIT = 1;
  localparam int RING_SEL_BIT   = 0;
  // ==========================================================
  // multimedia control bit positions
  localparam int VID_OE_BIT   = 7;
  localparam int VID_SEL_BIT  = 6;
  localparam int VID_EN1_BIT  = 1;
  localparam int VID_EN0_BIT  = 0;
  // ==========================================================
  // reset values and write mask
  localparam logic [7:0] MMCTL_RESET   = 8'h00;
  localparam logic [7:0] MMCTL_WMASK   = 8'hC3;
  localparam logic       ID_LOCK_RESET = 1'b1;
  // ==========================================================
  // settle delays
  localparam int CLK_MHZ        = 40;
  localparam int UP_SETTLE_US   = 50;
  localparam int DN_SETTLE_US   = 50;
  localparam int UP_SETTLE_CYC  = UP_SETTLE_US * CLK_MHZ;
  localparam int DN_SETTLE_CYC  = DN_SETTLE_US * CLK_MHZ;
  localparam int CNT_W          = 16;
endpackage : cbz_pkg

/* cbz_regs.sv */
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - bit 14 enables upstream memory read bursts; resets to 0.
// - bit 13 per socket sets on card access; clears when read.
// - bit 12 is read-only and always reads 1.
// - bit 11 reads 1 from stream start until the stream is done and its settle delay has expired.
// - bit 10 set after power-up stream, clears after up delay.
// - bit 9 set after power-down stream, clears after down delay.
// - bit 8 per socket reads 1 while card interrogation runs.
// - bit 7 is read-only and reads 0.
// - bit 6 stops idle clockless socket state machine clocking.
// - bit 5 locks ID registers when 1; defaults to 1.
// - bit 4 routes card data parity errors to host error signal.
// - bit 3 enables central DMA and silences mux pins 7 and 6.
// - bit 1 forbids stopping either clock via clock-run protocols.
// - bit 0 low shares pin, ring or wake asserts it; high passes wake only.
// - multimedia bit 7 enables video outputs; else high impedance.
// - multimedia bit 6 picks source socket if its video mode on.
// - multimedia bits 5 to 2 read zero, ignore writes.
// - multimedia bit 1 puts socket 1 in video mode, inputs only.
// - multimedia bit 0 puts socket 0 in video mode, inputs only.
// - multimedia register at 84h in both functions, reset 00h.
module cbz_regs
  import cbz_pkg::*;
#(
  parameter int VID_W = 16
)(
  input  wire logic             SYS_CLK_IN,
  input  wire logic             RESET_N_IN,
  input  wire logic             WB_CYC_IN,
  input  wire logic             WB_STB_IN,
  input  wire logic             WB_WE_IN,
  input  wire logic [7:0]       WB_ADR_IN,
  input  wire logic [3:0]       WB_SEL_IN,
  input  wire logic [31:0]      WB_DAT_IN,
  output logic      [31:0]      WB_DAT_OUT,
  output logic                  WB_ACK_OUT,
  input  wire logic             FUNC_SEL_IN,
  input  wire logic [1:0]       CARD_ACCESS_IN,
  input  wire logic [1:0]       PROBE_BUSY_IN,
  input  wire logic             PWR_UP_STREAM_IN,
  input  wire logic             PWR_DN_STREAM_IN,
  input  wire logic             STREAM_DONE_IN,
  input  wire logic [1:0]       CARD_IDLE_IN,
  input  wire logic [1:0]       CARD_CLK_STOPPED_IN,
  input  wire logic             PARITY_ERR_IN,
  input  wire logic             IRQ_MUX7_IN,
  input  wire logic             IRQ_MUX6_IN,
  input  wire logic             CARD_CLKRUN_REQ_IN,
  input  wire logic             HOST_CLKRUN_REQ_IN,
  input  wire logic             RING_IN,
  input  wire logic             WAKE_IN,
  input  wire logic [VID_W-1:0] VID0_IN,
  input  wire logic [VID_W-1:0] VID1_IN,
  output logic                  UP_BURST_EN_OUT,
  output logic      [1:0]       SOCK_SM_CLK_EN_OUT,
  output logic                  ID_WRITE_EN_OUT,
  output logic                  SERR_REQ_OUT,
  output logic                  DMA_EN_OUT,
  output logic                  INT_MUX7_OUT,
  output logic                  INT_MUX6_OUT,
  output logic                  CARD_CLK_STOP_OK_OUT,
  output logic                  HOST_CLK_STOP_OK_OUT,
  output logic                  RING_WAKE_OUT,
  output logic      [1:0]       VID_MODE_OUT,
  output logic      [VID_W-1:0] VID_OUT,
  output logic                  VID_OE_OUT
);

  // ==========================================================
  // state
  typedef struct packed {
    logic             ack;
    logic [31:0]      rdata;
    logic             up_burst;
    logic [1:0]       sock_seen;
    logic             stream;
    logic             up_pend;
    logic             dn_pend;
    logic [CNT_W-1:0] cnt;
    logic             gating;
    logic             id_lock;
    logic             par_en;
    logic             dma_en;
    logic             clk_inh;
    logic             ring_sel;
    logic [7:0]       mm;
    logic [VID_W-1:0] vid;
  } cbz_state_t;

  cbz_state_t st;
  cbz_state_t next_st;

  logic        req;
  logic        wr;
  logic        rd;
  logic        f0;
  logic [31:0] sysctl_val;
  logic [31:0] wmask;

  // ==========================================================
  // bus decode
  assign req = WB_CYC_IN && WB_STB_IN && !st.ack;
  assign wr  = req && WB_WE_IN;
  assign rd  = req && !WB_WE_IN;
  assign f0  = !FUNC_SEL_IN;
  assign wmask = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}},
                  {8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};

  always_comb
  begin
    sysctl_val = 32'h0000_0000;
    sysctl_val[UP_BURST_BIT]    = st.up_burst;
    sysctl_val[SOCK_SEEN_BIT]   = st.sock_seen[FUNC_SEL_IN];
    sysctl_val[RAIL_BIT]        = 1'b1;
    sysctl_val[STREAM_BIT]      = st.stream;
    sysctl_val[UP_SETTLE_BIT]   = st.up_pend;
    sysctl_val[DN_SETTLE_BIT]   = st.dn_pend;
    sysctl_val[PROBE_BIT]       = PROBE_BUSY_IN[FUNC_SEL_IN];
    sysctl_val[ZERO_BIT]        = 1'b0;
    sysctl_val[GATING_BIT]      = st.gating;
    sysctl_val[ID_LOCK_BIT]     = st.id_lock;
    sysctl_val[PAR_REPORT_BIT]  = st.par_en;
    sysctl_val[DMA_EN_BIT]      = st.dma_en;
    sysctl_val[CLK_INHIBIT_BIT] = st.clk_inh;
    sysctl_val[RING_SEL_BIT]    = st.ring_sel;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_st = st;
    next_st.ack = req;
    // socket activity: set wins over read clear
    if (rd && WB_ADR_IN == SYSCTL_ADDR && WB_SEL_IN[1])
    begin
      next_st.sock_seen[FUNC_SEL_IN] = 1'b0;
    end
    next_st.sock_seen = next_st.sock_seen | CARD_ACCESS_IN;
    // settle delays
    if (st.cnt != '0)
    begin
      next_st.cnt = st.cnt - 1'b1;
    end
    if (st.stream && STREAM_DONE_IN && st.cnt == '0
        && !st.up_pend && !st.dn_pend)
    begin
      next_st.stream = 1'b0;
    end
    if ((st.up_pend || st.dn_pend) && st.cnt == CNT_W'(1))
    begin
      next_st.up_pend = 1'b0;
      next_st.dn_pend = 1'b0;
    end
    if (PWR_UP_STREAM_IN)
    begin
      next_st.stream  = 1'b1;
      next_st.up_pend = 1'b1;
      next_st.dn_pend = 1'b0;
      next_st.cnt     = CNT_W'(UP_SETTLE_CYC);
    end
    else if (PWR_DN_STREAM_IN)
    begin
      next_st.stream  = 1'b1;
      next_st.dn_pend = 1'b1;
      next_st.up_pend = 1'b0;
      next_st.cnt     = CNT_W'(DN_SETTLE_CYC);
    end
    // register writes; global bits only via function 0
    if (wr && f0 && WB_ADR_IN == SYSCTL_ADDR)
    begin
      if (WB_SEL_IN[1])
      begin
        next_st.up_burst = WB_DAT_IN[UP_BURST_BIT];
      end
      if (WB_SEL_IN[0])
      begin
        next_st.gating   = WB_DAT_IN[GATING_BIT];
        next_st.id_lock  = WB_DAT_IN[ID_LOCK_BIT];
        next_st.par_en   = WB_DAT_IN[PAR_REPORT_BIT];
        next_st.dma_en   = WB_DAT_IN[DMA_EN_BIT];
        next_st.clk_inh  = WB_DAT_IN[CLK_INHIBIT_BIT];
        next_st.ring_sel = WB_DAT_IN[RING_SEL_BIT];
      end
    end
    if (wr && f0 && WB_ADR_IN == MMCTL_ADDR && WB_SEL_IN[0])
    begin
      next_st.mm = WB_DAT_IN[7:0] & MMCTL_WMASK;
    end
    // read data
    next_st.rdata = 32'h0000_0000;
    if (rd)
    begin
      case (WB_ADR_IN)
        SYSCTL_ADDR: next_st.rdata = sysctl_val & wmask;
        MMCTL_ADDR:  next_st.rdata = {24'h000000, st.mm} & wmask;
        default:     next_st.rdata = 32'h0000_0000;
      endcase
    end
    // video source mux
    if (st.mm[VID_SEL_BIT] && st.mm[VID_EN1_BIT])
    begin
      next_st.vid = VID1_IN;
    end
    else if (!st.mm[VID_SEL_BIT] && st.mm[VID_EN0_BIT])
    begin
      next_st.vid = VID0_IN;
    end
    else
    begin
      next_st.vid = '0;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      st          <= '0;
      st.id_lock  <= ID_LOCK_RESET;
      st.mm       <= MMCTL_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign WB_ACK_OUT = st.ack;
  assign WB_DAT_OUT = st.rdata;
  assign UP_BURST_EN_OUT = st.up_burst;
  assign SOCK_SM_CLK_EN_OUT =
    ~({2{st.gating}} & CARD_IDLE_IN & CARD_CLK_STOPPED_IN);
  assign ID_WRITE_EN_OUT = !st.id_lock;
  assign SERR_REQ_OUT = st.par_en && PARITY_ERR_IN;
  assign DMA_EN_OUT   = st.dma_en;
  assign INT_MUX7_OUT = IRQ_MUX7_IN && !st.dma_en;
  assign INT_MUX6_OUT = IRQ_MUX6_IN && !st.dma_en;
  assign CARD_CLK_STOP_OK_OUT = CARD_CLKRUN_REQ_IN && !st.clk_inh;
  assign HOST_CLK_STOP_OK_OUT = HOST_CLKRUN_REQ_IN && !st.clk_inh;
  assign RING_WAKE_OUT = st.ring_sel ? WAKE_IN
                                     : (RING_IN || WAKE_IN);
  assign VID_MODE_OUT = {st.mm[VID_EN1_BIT], st.mm[VID_EN0_BIT]};
  assign VID_OE_OUT = st.mm[VID_OE_BIT];
  assign VID_OUT = st.vid;

  // ==========================================================
  // checks
  property p_burst;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    wr && f0 && WB_ADR_IN == SYSCTL_ADDR && WB_SEL_IN[1]
    |=> UP_BURST_EN_OUT == $past(WB_DAT_IN[UP_BURST_BIT]);
  endproperty
  a_burst: assert property (p_burst)
    else $error("burst enable not stored");

  property p_seen;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    CARD_ACCESS_IN[0] |=> st.sock_seen[0];
  endproperty
  a_seen: assert property (p_seen)
    else $error("socket access lost");

  property p_rail;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    rd && WB_ADR_IN == SYSCTL_ADDR && WB_SEL_IN[1]
    |=> WB_ACK_OUT && WB_DAT_OUT[RAIL_BIT] && !WB_DAT_OUT[ZERO_BIT];
  endproperty
  a_rail: assert property (p_rail)
    else $error("fixed bits wrong");

  property p_stream;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (st.up_pend || st.dn_pend) |-> st.stream;
  endproperty
  a_stream: assert property (p_stream)
    else $error("stream cleared before delay");

  property p_up;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    PWR_UP_STREAM_IN |=> st.up_pend && st.cnt == CNT_W'(UP_SETTLE_CYC);
  endproperty
  a_up: assert property (p_up)
    else $error("power-up delay not started");

  property p_dn;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    !PWR_UP_STREAM_IN && PWR_DN_STREAM_IN |=> st.dn_pend && !st.up_pend;
  endproperty
  a_dn: assert property (p_dn)
    else $error("power-down delay not started");

  property p_dma;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    DMA_EN_OUT |-> !INT_MUX7_OUT && !INT_MUX6_OUT;
  endproperty
  a_dma: assert property (p_dma)
    else $error("mux pins active with dma");

  property p_vid;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    wr && f0 && WB_ADR_IN == MMCTL_ADDR && WB_SEL_IN[0]
    |=> VID_OE_OUT == $past(WB_DAT_IN[VID_OE_BIT]);
  endproperty
  a_vid: assert property (p_vid)
    else $error("video drivers do not follow enable bit");

  property p_rsv;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    st.mm[5:2] == 4'h0;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved video bits set");

  property p_seen_clr;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    rd && f0 && WB_ADR_IN == SYSCTL_ADDR && WB_SEL_IN[1]
    && !CARD_ACCESS_IN[0] |=> !st.sock_seen[0];
  endproperty
  a_seen_clr: assert property (p_seen_clr)
    else $error("socket activity not cleared by read");

  property p_settle;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (st.up_pend || st.dn_pend) && st.cnt == CNT_W'(1)
    && !PWR_UP_STREAM_IN && !PWR_DN_STREAM_IN
    |=> !st.up_pend && !st.dn_pend;
  endproperty
  a_settle: assert property (p_settle)
    else $error("settle status not cleared at delay end");

  property p_stream_done;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    st.stream && !st.up_pend && !st.dn_pend && st.cnt == '0
    && STREAM_DONE_IN && !PWR_UP_STREAM_IN && !PWR_DN_STREAM_IN
    |=> !st.stream;
  endproperty
  a_stream_done: assert property (p_stream_done)
    else $error("stream status stuck after completion");

  property p_wlock;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    wr && f0 && WB_ADR_IN == SYSCTL_ADDR && WB_SEL_IN[0]
    |=> ID_WRITE_EN_OUT == !$past(WB_DAT_IN[ID_LOCK_BIT]);
  endproperty
  a_wlock: assert property (p_wlock)
    else $error("id write lock not stored");

  property p_serr;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    !st.par_en |-> !SERR_REQ_OUT;
  endproperty
  a_serr: assert property (p_serr)
    else $error("parity error reported while disabled");

  property p_keep;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    st.clk_inh |-> !CARD_CLK_STOP_OK_OUT && !HOST_CLK_STOP_OK_OUT;
  endproperty
  a_keep: assert property (p_keep)
    else $error("clock stop allowed while inhibited");

  property p_ring;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    !st.ring_sel && RING_IN |-> RING_WAKE_OUT;
  endproperty
  a_ring: assert property (p_ring)
    else $error("ring indicate lost on shared pin");

  property p_gate;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    st.gating && CARD_IDLE_IN[0] && CARD_CLK_STOPPED_IN[0]
    |-> !SOCK_SM_CLK_EN_OUT[0];
  endproperty
  a_gate: assert property (p_gate)
    else $error("idle socket state machine still clocked");

  property p_vid_sel;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    st.mm[VID_SEL_BIT] && st.mm[VID_EN1_BIT]
    |=> VID_OUT == $past(VID1_IN);
  endproperty
  a_vid_sel: assert property (p_vid_sel)
    else $error("socket 1 video not routed");

endmodule : cbz_regs

/* tb_cbz_regs.sv */
`timescale 1ns/1ps
module tb_cbz_regs;
  import cbz_pkg::*;
  localparam logic [7:0] MM_TAB [5] = '{8'h80, 8'h81, 8'hC2, 8'hC1,
                                         8'h01};
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, fsel = 0;
  logic        pup = 0, pdn = 0, sdone = 0, perr = 0, m7 = 0, m6 = 0;
  logic        creq = 0, hreq = 0, ring = 0, wake = 0;
  logic [1:0]  acc = 0, probe = 0, idle = 0, cstop = 0, smclk, vmode;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] wdat = 0, rdat, q;
  logic [15:0] vid0, vid1, vout;
  logic        ack, burst, idwe, serr, dma, o7, o6, cok, hok, rw, voe;
  int          num_errors = 0, checks = 0;
  always #12.5 clk = ~clk;
  cbz_card_model #(.VID_W(16)) card_u (.clk_in(clk), .rst_n_in(rst_n),
    .vid0_out(vid0), .vid1_out(vid1));
  cbz_regs #(.VID_W(16)) dut_u (
    .SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .FUNC_SEL_IN(fsel), .CARD_ACCESS_IN(acc), .PROBE_BUSY_IN(probe),
    .PWR_UP_STREAM_IN(pup), .PWR_DN_STREAM_IN(pdn),
    .STREAM_DONE_IN(sdone), .CARD_IDLE_IN(idle),
    .CARD_CLK_STOPPED_IN(cstop), .PARITY_ERR_IN(perr),
    .IRQ_MUX7_IN(m7), .IRQ_MUX6_IN(m6), .CARD_CLKRUN_REQ_IN(creq),
    .HOST_CLKRUN_REQ_IN(hreq), .RING_IN(ring), .WAKE_IN(wake),
    .VID0_IN(vid0), .VID1_IN(vid1), .UP_BURST_EN_OUT(burst),
    .SOCK_SM_CLK_EN_OUT(smclk), .ID_WRITE_EN_OUT(idwe),
    .SERR_REQ_OUT(serr), .DMA_EN_OUT(dma), .INT_MUX7_OUT(o7),
    .INT_MUX6_OUT(o6), .CARD_CLK_STOP_OK_OUT(cok),
    .HOST_CLK_STOP_OK_OUT(hok), .RING_WAKE_OUT(rw),
    .VID_MODE_OUT(vmode), .VID_OUT(vout), .VID_OE_OUT(voe));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    do
    begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic end_sim;
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk(32'(idwe), 32'h0);
    wb(1'b0, SYSCTL_ADDR, 32'h0);
    chk(q, 32'h00001020);
    wb(1'b0, MMCTL_ADDR, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, STATUS_ADDR, 32'h0);
    chk(q, 32'h0);
  endtask : t_reset
  task automatic t_ctrl;
    {perr, m7, m6, creq, hreq, ring} <= 6'h3F;
    idle  <= 2'h3;
    cstop <= 2'h3;
    fsel  <= 1'b1;
    wb(1'b1, SYSCTL_ADDR, 32'h0000405B);
    fsel  <= 1'b0;
    wb(1'b0, SYSCTL_ADDR, 32'h0);
    chk(q, 32'h00001020);
    q = 32'({burst, idwe, serr, dma, o7, o6, cok, hok, rw, smclk});
    chk(q, 32'h0000007F);
    wb(1'b1, SYSCTL_ADDR, 32'h0000405B);
    wb(1'b0, SYSCTL_ADDR, 32'h0);
    chk(q, 32'h0000505B);
    q = 32'({burst, idwe, serr, dma, o7, o6, cok, hok, rw, smclk});
    chk(q, 32'h00000780);
    wake <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(rw), 32'h1);
  endtask : t_ctrl
  task automatic t_act;
    acc <= 2'h1;
    @(posedge clk);
    acc <= 2'h0;
    wb(1'b0, SYSCTL_ADDR, 32'h0);
    chk(q, 32'h0000705B);
    wb(1'b0, SYSCTL_ADDR, 32'h0);
    chk(q, 32'h0000505B);
    probe <= 2'h2;
    fsel  <= 1'b1;
    wb(1'b0, SYSCTL_ADDR, 32'h0);
    chk(q, 32'h0000515B);
    fsel  <= 1'b0;
    wb(1'b0, SYSCTL_ADDR, 32'h0);
    chk(q, 32'h0000505B);
  endtask : t_act
  task automatic t_pwr(input logic up);
    logic [31:0] busy;
    busy = up ? 32'h00005C5B : 32'h00005A5B;
    sdone <= 1'b0;
    pup   <= up;
    pdn   <= ~up;
    @(posedge clk);
    pup   <= 1'b0;
    pdn   <= 1'b0;
    sdone <= 1'b1;
    wb(1'b0, SYSCTL_ADDR, 32'h0);
    chk(q, busy);
    repeat ((up ? UP_SETTLE_CYC : DN_SETTLE_CYC) - 50) @(posedge clk);
    wb(1'b0, SYSCTL_ADDR, 32'h0);
    chk(q, busy);
    repeat (100) @(posedge clk);
    wb(1'b0, SYSCTL_ADDR, 32'h0);
    chk(q, 32'h0000505B);
  endtask : t_pwr
  task automatic t_vid;
    logic [7:0]  m;
    logic [15:0] e;
    wb(1'b1, MMCTL_ADDR, 32'h000000FF);
    fsel <= 1'b1;
    wb(1'b0, MMCTL_ADDR, 32'h0);
    chk(q, 32'h000000C3);
    fsel <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      m = MM_TAB[i];
      wb(1'b1, MMCTL_ADDR, {24'h0, m});
      e = m[6] ? ~(vid0 - 16'h1) : vid0 - 16'h1;
      if (!(m[6] ? m[1] : m[0]))
        e = 16'h0;
      chk(32'({vmode, voe}), 32'({m[1:0], m[7]}));
      chk(32'(vout), 32'(e));
    end
  endtask : t_vid
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_ctrl;
    t_act;
    t_pwr(1'b1);
    t_pwr(1'b0);
    t_vid;
    end_sim;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim;
  end
endmodule : tb_cbz_regs
